/* gcbr_consts.svh */
// Purpose: named offsets, reset values and widths for the global bus range decode
// Assumes: byte-wide configuration space access at byte offsets
// Notes: definitions only
`ifndef GCBR_CONSTS_SVH
`define GCBR_CONSTS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define GCBR_ADDR_W 12
`define GCBR_BUS_W 8

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define GCBR_OFS_LOW 12'h134
`define GCBR_OFS_HIGH 12'h135
`define GCBR_LOW_RST 8'h00
`define GCBR_HIGH_RST 8'hff
`define GCBR_RDATA_IDLE 8'h00

`endif

/* gcbr_pkg.sv */
// Purpose: shared types of the global bus range decode
// Assumes: constants come from gcbr_consts.svh
// Notes: no timing figures live here
package gcbr_pkg;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [7:0] gcbr_bus_t;

    typedef enum logic [1:0] {
        GCBR_ROUTE_NONE,
        GCBR_ROUTE_LOCAL,
        GCBR_ROUTE_REMOTE,
        GCBR_ROUTE_UNCLAIMED
    } gcbr_route_e;

    typedef enum logic [1:0] {
        GCBR_SEL_NONE,
        GCBR_SEL_LOW,
        GCBR_SEL_HIGH
    } gcbr_sel_e;

endpackage : gcbr_pkg

/* gcbr_range_cmp.sv */
// Purpose: inclusive window compare of one bus number
// Assumes: lo greater than hi simply matches nothing
// Notes: purely combinational
`timescale 1ns/10ps
module gcbr_range_cmp
    import gcbr_pkg::*;
(
    input wire gcbr_bus_t value,
    input wire gcbr_bus_t lo,
    input wire gcbr_bus_t hi,
    output logic hit
);

    // ----------------------------------------------------------------
    // compare
    // ----------------------------------------------------------------
    always_comb begin
        hit = (value >= lo) && (value <= hi);
    end

endmodule : gcbr_range_cmp

/* gcbr_global_cfg_bus_decode.sv */
// Purpose: global configuration bus-number range registers and routing decode
// Assumes: transactions and local range come from logic on ref_clk
// Notes: one decision per taken transaction, one cycle later
`timescale 1ns/10ps
`include "gcbr_consts.svh"
module gcbr_global_cfg_bus_decode
    import gcbr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [`GCBR_ADDR_W-1:0] cfg_addr,
    input wire gcbr_bus_t cfg_wdata,
    output gcbr_bus_t cfg_rdata,
    output logic cfg_rvalid,
    input wire logic txn_valid,
    input wire gcbr_bus_t txn_bus,
    input wire logic txn_outbound,
    input wire gcbr_bus_t local_bus_low,
    input wire gcbr_bus_t local_bus_high,
    output logic route_valid,
    output gcbr_route_e route_kind,
    output gcbr_bus_t route_bus,
    output logic route_outbound
);

    // ----------------------------------------------------------------
    // register select
    // ----------------------------------------------------------------
    function automatic gcbr_sel_e reg_sel(input logic [`GCBR_ADDR_W-1:0] addr);
        gcbr_sel_e sel;
        sel = GCBR_SEL_NONE;
        if (addr == `GCBR_OFS_LOW) begin
            sel = GCBR_SEL_LOW;
        end else if (addr == `GCBR_OFS_HIGH) begin
            sel = GCBR_SEL_HIGH;
        end
        return sel;
    endfunction : reg_sel

    gcbr_bus_t global_bus_range_low;
    gcbr_bus_t global_bus_range_high;
    logic global_hit;
    logic local_hit;
    gcbr_route_e next_route;

    // ----------------------------------------------------------------
    // range registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            global_bus_range_low <= `GCBR_LOW_RST;
        end else if (ce && cfg_wr && reg_sel(cfg_addr) == GCBR_SEL_LOW) begin
            global_bus_range_low <= cfg_wdata;
        end
    end

    // written freely; software is trusted to set it only at boot
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            global_bus_range_high <= `GCBR_HIGH_RST;
        end else if (ce && cfg_wr && reg_sel(cfg_addr) == GCBR_SEL_HIGH) begin
            global_bus_range_high <= cfg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_rvalid <= 1'b0;
            cfg_rdata <= `GCBR_RDATA_IDLE;
        end else if (ce) begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                case (reg_sel(cfg_addr))
                    GCBR_SEL_LOW: begin
                        cfg_rdata <= global_bus_range_low;
                    end
                    GCBR_SEL_HIGH: begin
                        cfg_rdata <= global_bus_range_high;
                    end
                    default: begin
                        cfg_rdata <= `GCBR_RDATA_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // range compare
    // ----------------------------------------------------------------
    gcbr_range_cmp u_global_cmp (
        .value(txn_bus),
        .lo(global_bus_range_low),
        .hi(global_bus_range_high),
        .hit(global_hit)
    );

    gcbr_range_cmp u_local_cmp (
        .value(txn_bus),
        .lo(local_bus_low),
        .hi(local_bus_high),
        .hit(local_hit)
    );

    // ----------------------------------------------------------------
    // route decision
    // ----------------------------------------------------------------
    // local hit checked first so an overlap never leaves the hub
    always_comb begin
        if (local_hit) begin
            next_route = GCBR_ROUTE_LOCAL;
        end else if (global_hit) begin
            next_route = GCBR_ROUTE_REMOTE;
        end else begin
            next_route = GCBR_ROUTE_UNCLAIMED;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            route_valid <= 1'b0;
        end else if (ce) begin
            route_valid <= txn_valid;
        end
    end

    // decision holds until the next taken transaction
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            route_kind <= GCBR_ROUTE_NONE;
            route_bus <= `GCBR_LOW_RST;
            route_outbound <= 1'b0;
        end else if (ce && txn_valid) begin
            route_kind <= next_route;
            route_bus <= txn_bus;
            route_outbound <= txn_outbound;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_rd_low;
        ce && cfg_rd && cfg_addr == `GCBR_OFS_LOW;
    endsequence

    sequence s_rd_high;
        ce && cfg_rd && cfg_addr == `GCBR_OFS_HIGH;
    endsequence

    sequence s_remote_txn;
        ce && txn_valid && !local_hit && global_hit;
    endsequence

    a_low_reset_val: assert property (
        $fell(rst) |-> global_bus_range_low == `GCBR_LOW_RST)
        else $error("global low bound not zero after reset");

    a_high_reset_val: assert property (
        $fell(rst) |-> global_bus_range_high == `GCBR_HIGH_RST)
        else $error("global high bound not all ones after reset");

    a_low_read_back: assert property (
        s_rd_low |=> cfg_rvalid && cfg_rdata == $past(global_bus_range_low))
        else $error("low bound read returned wrong value");

    a_high_write_read: assert property (
        ce && cfg_wr && cfg_addr == `GCBR_OFS_HIGH ##1 s_rd_high
        |=> cfg_rdata == $past(cfg_wdata, 2))
        else $error("high bound write not seen on read");

    a_inclusive_ends: assert property (
        ce && txn_valid && !local_hit
        && (txn_bus == global_bus_range_low || txn_bus == global_bus_range_high)
        && global_bus_range_low <= global_bus_range_high
        |=> route_valid && route_kind == GCBR_ROUTE_REMOTE)
        else $error("bound value not treated as inside global range");

    a_outside_unclaimed: assert property (
        ce && txn_valid && !local_hit
        && (txn_bus < global_bus_range_low || txn_bus > global_bus_range_high)
        |=> route_kind == GCBR_ROUTE_UNCLAIMED)
        else $error("bus number outside both ranges was claimed");

    a_remote_route: assert property (
        s_remote_txn |=> route_valid && route_kind == GCBR_ROUTE_REMOTE
        && route_bus == $past(txn_bus) && route_outbound == $past(txn_outbound))
        else $error("global-only hit not routed remote");

    a_local_wins: assert property (
        ce && txn_valid && local_hit |=> route_kind == GCBR_ROUTE_LOCAL)
        else $error("local range hit routed away from the hub");

    // only a taken transaction may move the held decision
    a_route_held: assert property (
        !(ce && txn_valid) |=> $stable(route_kind) && $stable(route_bus))
        else $error("route decision changed without a transaction");

    a_ce_freeze: assert property (
        !ce |=> $stable(global_bus_range_low) && $stable(global_bus_range_high)
        && $stable(cfg_rvalid) && $stable(route_valid))
        else $error("state moved while clock enable was low");

    a_route_pulse: assert property (
        ce && !txn_valid |=> !route_valid)
        else $error("decision flagged without a taken transaction");

    a_rvalid_pulse: assert property (
        ce && !cfg_rd |=> !cfg_rvalid)
        else $error("read valid flagged without a read");

endmodule : gcbr_global_cfg_bus_decode

/* gcbr_hub_model.sv */
// Purpose: far side of the decode, local range source and remote hub sink
// Assumes: local range is static while traffic runs
// Notes: counts every transaction handed over as remote peer-to-peer
`timescale 1ns/10ps
module gcbr_hub_model import gcbr_pkg::*; #(
    parameter gcbr_bus_t LOCAL_LOW = 8'h00,
    parameter gcbr_bus_t LOCAL_HIGH = 8'h0f
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic route_valid,
    input wire gcbr_route_e route_kind,
    output gcbr_bus_t local_bus_low,
    output gcbr_bus_t local_bus_high,
    output int remote_seen
);
    assign local_bus_low = LOCAL_LOW;
    assign local_bus_high = LOCAL_HIGH;

    // remote hubs accept one transaction per pulse, never stall
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            remote_seen <= 0;
        end else if (route_valid && route_kind == GCBR_ROUTE_REMOTE) begin
            remote_seen <= remote_seen + 1;
        end
    end
endmodule : gcbr_hub_model

/* test_global_cfg_bus_range_decode.sv */
// Purpose: self-checking bench of the global bus range decode
// Assumes: ce high except for one dropped write, local range 0x00-0x0f from the hub model
// Notes: inverted bounds used to show an empty global window
`timescale 1ns/10ps
`include "gcbr_consts.svh"
module test_global_cfg_bus_range_decode import gcbr_pkg::*;;
    logic ref_clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, ce = 1'b1;
    logic txn_valid = 1'b0, txn_outbound = 1'b0, cfg_rvalid, route_valid, route_outbound;
    logic [`GCBR_ADDR_W-1:0] cfg_addr = '0;
    gcbr_bus_t cfg_wdata = '0, txn_bus = '0, cfg_rdata, route_bus, lo_b, hi_b, d;
    gcbr_bus_t local_bus_low, local_bus_high;
    gcbr_route_e route_kind;
    gcbr_bus_t buses[6] = '{8'h05, 8'h0f, 8'h10, 8'h30, 8'h31, 8'hff};
    int n_errors = 0, total_checks = 0, remote_seen, n_remote = 0;

    always #4 ref_clk = ~ref_clk;

    gcbr_global_cfg_bus_decode u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .txn_valid(txn_valid),
        .txn_bus(txn_bus), .txn_outbound(txn_outbound), .local_bus_low(local_bus_low),
        .local_bus_high(local_bus_high), .route_valid(route_valid),
        .route_kind(route_kind), .route_bus(route_bus), .route_outbound(route_outbound));

    gcbr_hub_model u_hub (.ref_clk(ref_clk), .rst(rst), .route_valid(route_valid),
        .route_kind(route_kind), .local_bus_low(local_bus_low),
        .local_bus_high(local_bus_high), .remote_seen(remote_seen));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task report_and_stop;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [11:0] a, input gcbr_bus_t v);
        @(posedge ref_clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= v;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [11:0] a, output gcbr_bus_t v);
        @(posedge ref_clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge ref_clk);
        cfg_rd <= 1'b0;
        #1;
        chk({7'h00, cfg_rvalid}, 8'h01);
        v = cfg_rdata;
    endtask : rd

    // read lands in the cycle right after the write
    task wr_rd(input logic [11:0] a, input gcbr_bus_t v, output gcbr_bus_t r);
        wr(a, v);
        cfg_rd <= 1'b1;
        @(posedge ref_clk);
        cfg_rd <= 1'b0;
        #1;
        chk({7'h00, cfg_rvalid}, 8'h01);
        r = cfg_rdata;
    endtask : wr_rd

    // local hit wins over global, so its test comes first
    function automatic gcbr_route_e want(input gcbr_bus_t b);
        if (b >= local_bus_low && b <= local_bus_high) return GCBR_ROUTE_LOCAL;
        if (b >= lo_b && b <= hi_b) return GCBR_ROUTE_REMOTE;
        return GCBR_ROUTE_UNCLAIMED;
    endfunction : want

    task txn(input gcbr_bus_t b, input logic o);
        @(posedge ref_clk);
        txn_valid <= 1'b1;
        txn_bus <= b;
        txn_outbound <= o;
        @(posedge ref_clk);
        txn_valid <= 1'b0;
        #1;
        if (want(b) == GCBR_ROUTE_REMOTE) n_remote++;
        chk({6'h00, route_kind}, {6'h00, want(b)});
        chk({route_outbound, route_valid}, {o, 1'b1});
        chk(route_bus, b);
    endtask : txn

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk({route_valid, route_kind}, {1'b0, GCBR_ROUTE_NONE});
        chk(route_bus, 8'h00);
        rd(`GCBR_OFS_LOW, d);
        chk(d, `GCBR_LOW_RST);
        rd(`GCBR_OFS_HIGH, d);
        chk(d, `GCBR_HIGH_RST);
        rd(12'h136, d);
        chk(d, `GCBR_RDATA_IDLE);
        lo_b = `GCBR_LOW_RST;
        hi_b = `GCBR_HIGH_RST;
        foreach (buses[i]) txn(buses[i], i[0]);
        lo_b = 8'h10;
        hi_b = 8'h30;
        wr(`GCBR_OFS_LOW, lo_b);
        wr_rd(`GCBR_OFS_HIGH, hi_b, d);
        chk(d, hi_b);
        rd(`GCBR_OFS_LOW, d);
        chk(d, lo_b);
        foreach (buses[i]) txn(buses[i], ~i[0]);
        lo_b = 8'h80;
        wr(`GCBR_OFS_LOW, lo_b);
        foreach (buses[i]) txn(buses[i], i[0]);
        // a write while clock enable is low must be lost
        @(posedge ref_clk);
        ce <= 1'b0;
        wr(`GCBR_OFS_LOW, 8'h55);
        ce <= 1'b1;
        rd(`GCBR_OFS_LOW, d);
        chk(d, lo_b);
        chk(remote_seen[7:0], n_remote[7:0]);
        report_and_stop;
    end

    // full run needs about 60 cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        report_and_stop;
    end
endmodule : test_global_cfg_bus_range_decode
